/* logic/dcf_pkg.sv */
/*
 * dcf_pkg: shared constants and carrier types of the decimation,
 * clock-source and ratio control block.
 * assumes: compiled before every other file of the block.
 */
package dcf_pkg;

    // ratio select holds 3 bits; log2 of the overall ratio is base plus select
    localparam int unsigned SEL_W = 3;
    localparam logic [3:0] RATIO_LOG2_BASE = 4'h7;     // select 0 means 128
    localparam logic [3:0] SINC3_LOG2_MAX = 4'ha;      // third-order stage stops at 1024
    localparam int unsigned CNT_W = 14;                // counts up to 16384 modulator ticks
    localparam int unsigned DP_W = 36;                 // datapath width, holds 2^34 full scale
    localparam logic [5:0] NORM_LOG2 = 6'h22;          // normalised full scale exponent, 34
    localparam int unsigned OUT_W = 24;
    localparam int unsigned OUT_LSB = 12;              // output takes datapath bits 35:12
    localparam logic [1:0] FAST_CONVS = 2'h2;          // conversions served by the fast path
    localparam logic [1:0] DIV_RATIO = 2'h2;           // modulator clock = master / 2

    // nominal master clock per mode, in kHz
    localparam logic [13:0] MCLK_HIGH_RESOLUTION_KHZ = 14'h2000; // 8192 kHz
    localparam logic [13:0] MCLK_LOW_POWER_KHZ = 14'h1000; // 4096 kHz
    localparam logic [13:0] MCLK_VERY_LOW_POWER_KHZ = 14'h0800; // 2048 kHz

    // block clock, informational only: nothing here is timed in ns
    localparam int unsigned CLK_PERIOD_NS = 25;

    typedef enum logic [1:0] {
        DCF_HIGH_RESOLUTION_MODE,
        DCF_LOW_POWER_MODE,
        DCF_VERY_LOW_POWER_MODE,
        DCF_MODE_RESERVED
    } dcf_mode_t;

    // one decimated word with its strobe
    typedef struct packed {
        logic valid;
        logic last;
        logic signed [DP_W-1:0] data;
    } dcf_word_t;

endpackage

/* logic/dcf_sinc1.sv */
/*
 * dcf_sinc1: first-order sinc stage that sums a run of input words and
 * emits the sum on the word flagged last.
 * assumes: input strobes are at least two cycles apart; last closes a run.
 */
`timescale 1ns/10ps
module dcf_sinc1 (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire dcf_pkg::dcf_word_t in_i,
    output dcf_pkg::dcf_word_t out_o
);
    logic signed [dcf_pkg::DP_W-1:0] acc_q;
    logic first_q;

    // running sum, restarted after each closed run
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= '0;
            first_q <= 1'b1;
        end else if (in_i.valid) begin
            acc_q <= first_q ? in_i.data : acc_q + in_i.data;
            first_q <= in_i.last;
        end
    end

    // result register: one-cycle strobe with the completed sum
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_o <= '0;
        end else begin
            out_o.valid <= in_i.valid & in_i.last;
            out_o.last <= 1'b1;
            if (in_i.valid & in_i.last) begin
                out_o.data <= first_q ? in_i.data : acc_q + in_i.data;
            end
        end
    end

endmodule // dcf_sinc1

/* logic/dcf_top.sv */
/*
 * dcf_top: modulator clock divider, clock source control and the
 * decimation path (third-order sinc, follow-on first-order sinc, and a
 * fast-settling first-order path used right after reset).
 * assumes: clk_sys_i is the selected master clock; mod_bit_i is the
 * modulator bitstream, sampled on the cycle where mod_clk_o is high.
 */
// Function
// - modulator clock is master clock halved
// - one output word per ratio modulator ticks
// - three-bit ratio field, 128 up to 16384
// - two-bit power mode picks three modes
// - nominal master clock 8.192/4.096/2.048 MHz
// - master clock from pin or crystal oscillator
// - bitstream feeds sinc3 and fast path together
// - linear-phase averaging sinc low-pass then decimate
// - fast path for two conversions, then sinc3
// - ratios 2048+ use sinc3 1024 plus sinc1
`timescale 1ns/10ps
module dcf_top (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic mod_bit_i,
    input wire logic [2:0] decimation_ratio_sel_i,
    input wire logic [1:0] power_mode_sel_i,
    input wire logic crystal_sel_i,
    output logic mod_clk_o,
    output logic osc_enable_o,
    output logic [1:0] power_mode_o,
    output logic [13:0] nominal_mclk_khz_o,
    output logic fast_path_o,
    output logic data_valid_o,
    output logic [23:0] data_o
);
    // log2 of the overall ratio from the select code
    function automatic logic [3:0] ratio_log2(input logic [2:0] sel);
        return dcf_pkg::RATIO_LOG2_BASE + {1'b0, sel};
    endfunction

    // log2 of the third-order stage ratio, capped at 1024
    function automatic logic [3:0] sinc3_log2(input logic [2:0] sel);
        logic [3:0] k;
        k = ratio_log2(sel);
        return (k > dcf_pkg::SINC3_LOG2_MAX) ? dcf_pkg::SINC3_LOG2_MAX : k;
    endfunction

    logic phase_q;
    logic tick;
    logic [13:0] cnt_q;
    logic [13:0] n_m1;
    logic [13:0] n3_m1;
    logic frame_end;
    logic sinc3_end;
    logic signed [35:0] sample;
    logic signed [35:0] int1_q, int2_q, int3_q;
    logic signed [35:0] dl1_q, dl2_q, dl3_q;
    logic signed [35:0] c1, c2, c3;
    logic dec_stb_q;
    logic dec_last_q;
    dcf_pkg::dcf_word_t comb_q;
    dcf_pkg::dcf_word_t s1_out;
    logic signed [35:0] fast_acc_q;
    logic signed [35:0] fast_snap_q;
    logic [1:0] conv_q;
    logic [5:0] g3;
    logic signed [35:0] norm;
    dcf_pkg::dcf_mode_t mode;

    // divide by two: modulator clock toggles every master clock edge
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= 1'b0;
            mod_clk_o <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            mod_clk_o <= ~phase_q;
        end
    end
    assign tick = phase_q; // one modulator tick per two master clocks

    // ratio decode; select is used live, so change it only between frames
    assign n_m1 = 14'((15'h1 << ratio_log2(decimation_ratio_sel_i)) - 15'h1);
    assign n3_m1 = 14'((15'h1 << sinc3_log2(decimation_ratio_sel_i)) - 15'h1);
    assign frame_end = tick && (cnt_q == n_m1);
    assign sinc3_end = tick && ((cnt_q & n3_m1) == n3_m1);
    assign sample = mod_bit_i ? 36'sh000000001 : -36'sh000000001;

    // frame counter in modulator ticks
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= frame_end ? 14'h0000 : cnt_q + 14'h0001;
        end
    end

    // three integrators at modulator rate; wraparound is harmless in a cic
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int1_q <= '0;
            int2_q <= '0;
            int3_q <= '0;
        end else if (tick) begin
            int1_q <= int1_q + sample;
            int2_q <= int2_q + int1_q;
            int3_q <= int3_q + int2_q;
        end
    end

    // decimation strobe one cycle after the stage boundary
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dec_stb_q <= 1'b0;
            dec_last_q <= 1'b0;
        end else begin
            dec_stb_q <= sinc3_end;
            dec_last_q <= frame_end;
        end
    end

    // three combs at the decimated rate
    assign c1 = int3_q - dl1_q;
    assign c2 = c1 - dl2_q;
    assign c3 = c2 - dl3_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dl1_q <= '0;
            dl2_q <= '0;
            dl3_q <= '0;
            comb_q <= '0;
        end else begin
            comb_q.valid <= dec_stb_q;
            if (dec_stb_q) begin
                dl1_q <= int3_q;
                dl2_q <= c1;
                dl3_q <= c2;
                comb_q.data <= c3;
                comb_q.last <= dec_last_q;
            end
        end
    end

    // remaining factor of 2..16 for long ratios, pass-through otherwise
    dcf_sinc1 u_sinc1 (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_i(comb_q),
        .out_o(s1_out)
    );

    // fast-settling path: plain running average over the whole frame
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fast_acc_q <= '0;
            fast_snap_q <= '0;
        end else if (tick) begin
            fast_acc_q <= frame_end ? 36'sh000000000 : fast_acc_q + sample;
            if (frame_end) begin
                fast_snap_q <= fast_acc_q + sample;
            end
        end
    end

    // conversion count decides the path; sticks on sinc3 until reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conv_q <= 2'h0;
        end else if (s1_out.valid && conv_q != dcf_pkg::FAST_CONVS) begin
            conv_q <= conv_q + 2'h1;
        end
    end

    // scale both paths to the same full scale before the output register
    assign g3 = 6'(3 * sinc3_log2(decimation_ratio_sel_i))
        + 6'(ratio_log2(decimation_ratio_sel_i) - sinc3_log2(decimation_ratio_sel_i));
    assign norm = (conv_q != dcf_pkg::FAST_CONVS)
        ? (fast_snap_q <<< (dcf_pkg::NORM_LOG2 - 6'(ratio_log2(decimation_ratio_sel_i))))
        : (s1_out.data <<< (dcf_pkg::NORM_LOG2 - g3));

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_valid_o <= 1'b0;
            data_o <= '0;
            fast_path_o <= 1'b1;
        end else begin
            data_valid_o <= s1_out.valid;
            fast_path_o <= (conv_q != dcf_pkg::FAST_CONVS);
            if (s1_out.valid) begin
                data_o <= norm[dcf_pkg::OUT_LSB +: dcf_pkg::OUT_W];
            end
        end
    end

    // power mode and its nominal master clock; reserved code kept as very low power
    always_comb begin
        mode = dcf_pkg::dcf_mode_t'(power_mode_sel_i);
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_mode_o <= 2'h0;
            nominal_mclk_khz_o <= dcf_pkg::MCLK_HIGH_RESOLUTION_KHZ;
        end else begin
            unique case (mode)
                dcf_pkg::DCF_HIGH_RESOLUTION_MODE: begin
                    power_mode_o <= 2'h0;
                    nominal_mclk_khz_o <= dcf_pkg::MCLK_HIGH_RESOLUTION_KHZ;
                end
                dcf_pkg::DCF_LOW_POWER_MODE: begin
                    power_mode_o <= 2'h1;
                    nominal_mclk_khz_o <= dcf_pkg::MCLK_LOW_POWER_KHZ;
                end
                dcf_pkg::DCF_VERY_LOW_POWER_MODE, dcf_pkg::DCF_MODE_RESERVED: begin
                    power_mode_o <= 2'h2;
                    nominal_mclk_khz_o <= dcf_pkg::MCLK_VERY_LOW_POWER_KHZ;
                end
            endcase
        end
    end

    // crystal oscillator runs only while it is the chosen source
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_enable_o <= 1'b0;
        end else begin
            osc_enable_o <= crystal_sel_i;
        end
    end

    // helper: master clocks between output words, for the frame check
    logic [15:0] gap_q;
    logic seen_q;
    logic [2:0] last_sel_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_q <= '0;
            seen_q <= 1'b0;
            last_sel_q <= 3'h0;
        end else begin
            gap_q <= data_valid_o ? 16'h0001 : gap_q + 16'h0001;
            seen_q <= data_valid_o ? 1'b1 : (seen_q && last_sel_q == decimation_ratio_sel_i);
            last_sel_q <= decimation_ratio_sel_i;
        end
    end

    // the edge of release still sees the reset value, so start one edge later
    chk_mod_clk_toggle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(nrst_i) |-> (mod_clk_o != $past(mod_clk_o)))
        else $error("modulator clock not at half master rate");
    chk_frame_gap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (data_valid_o && seen_q) |-> (17'(gap_q) == (17'h1 << (ratio_log2(last_sel_q) + 4'h1))))
        else $error("output word spacing differs from twice the ratio");
    chk_valid_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        data_valid_o |=> !data_valid_o)
        else $error("output strobe longer than one cycle");
    chk_ratio_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cnt_q <= n_m1)
        else $error("frame counter beyond the selected ratio");
    chk_mode_clock: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (power_mode_o == 2'h1) |-> (nominal_mclk_khz_o == 14'h1000))
        else $error("low power mode with wrong nominal clock");
    chk_osc_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !crystal_sel_i ##1 !crystal_sel_i |-> !osc_enable_o)
        else $error("oscillator left on with external clock");
    chk_sinc3_cap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        sinc3_end |-> (n3_m1 <= 14'h03ff) ##2 comb_q.valid)
        else $error("third-order stage beyond 1024 or comb missed");
    chk_fast_then_sinc3: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!fast_path_o) |=> (!fast_path_o))
        else $error("returned to fast path without reset");
    chk_fast_two_words: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (s1_out.valid && conv_q == 2'h1) |=> ##1 !fast_path_o)
        else $error("fast path not left after two conversions");

    cov_first_word: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        data_valid_o && fast_path_o);
    cov_sinc3_word: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        data_valid_o && !fast_path_o);
    cov_long_ratio: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s1_out.valid && decimation_ratio_sel_i == 3'h4);
    cov_crystal: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        osc_enable_o);

endmodule // dcf_top

/* verif/dcf_mod_source.sv */
/*
 * dcf_mod_source: stand-in for the modulator and master clock side,
 * feeding a one-bit stream into the decimation block.
 * assumes: clk_sys_i is the master clock made by the bench; the bench
 * picks the pattern and supplies the random bit.
 */
`timescale 1ns/10ps
module dcf_mod_source (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [1:0] pattern_i,
    input wire logic rnd_bit_i,
    output logic mod_bit_o
);
    // bit moves only on master edges, so the stream stays locked to that clock
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mod_bit_o <= 1'b0;
        end else begin
            case (pattern_i)
                2'h0: mod_bit_o <= 1'b0; // steady -1
                2'h1: mod_bit_o <= 1'b1; // steady +1
                2'h2: mod_bit_o <= rnd_bit_i;
                default: mod_bit_o <= ~mod_bit_o; // mid-scale toggling
            endcase
        end
    end
endmodule // dcf_mod_source

/* verif/tb_decimation_clock_osr_control.sv */
/*
 * tb_decimation_clock_osr_control: self-checking bench for dcf_top with
 * a modulator stand-in; steady and random bitstreams, all ratio codes.
 * assumes: dcf_top keeps the latencies and full-scale figure of its notes.
 */
`timescale 1ns/10ps
module tb_decimation_clock_osr_control;
    logic clk_sys_i;
    logic nrst_i;
    logic mod_bit;
    logic [2:0] ratio_sel;
    logic [1:0] mode_sel;
    logic crystal_sel;
    logic [1:0] pattern;
    logic rnd_bit;
    logic mod_clk;
    logic osc_en;
    logic [1:0] mode_seen;
    logic [13:0] khz_seen;
    logic fast_path;
    logic data_valid;
    logic [23:0] data;
    logic [31:0] lfsr_q = 32'hb0d477ad;
    int bad_count;
    int total_checks;
    int base_lat;
    int lat;
    int edge_n;
    int bit_sum;

    dcf_top dut_u (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .mod_bit_i(mod_bit),
        .decimation_ratio_sel_i(ratio_sel),
        .power_mode_sel_i(mode_sel),
        .crystal_sel_i(crystal_sel),
        .mod_clk_o(mod_clk),
        .osc_enable_o(osc_en),
        .power_mode_o(mode_seen),
        .nominal_mclk_khz_o(khz_seen),
        .fast_path_o(fast_path),
        .data_valid_o(data_valid),
        .data_o(data)
    );

    dcf_mod_source src_u (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pattern_i(pattern),
        .rnd_bit_i(rnd_bit),
        .mod_bit_o(mod_bit)
    );

    // 40 MHz master clock, stands in for the nominal mode clocks
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [1:0] exp_mode(input logic [1:0] m);
        return (m == 2'h3) ? 2'h2 : m;
    endfunction

    function automatic logic [13:0] exp_khz(input logic [1:0] m);
        case (exp_mode(m))
            2'h0: return dcf_pkg::MCLK_HIGH_RESOLUTION_KHZ;
            2'h1: return dcf_pkg::MCLK_LOW_POWER_KHZ;
            default: return dcf_pkg::MCLK_VERY_LOW_POWER_KHZ;
        endcase
    endfunction

    // fast path word: a whole frame of +1 lands on the common full scale
    function automatic logic [23:0] exp_fast(input int sum, input int sel);
        return 24'(sum * (1 << (int'(dcf_pkg::NORM_LOG2) - int'(dcf_pkg::OUT_LSB) - 7 - sel)));
    endfunction

    // lfsr steps on the falling edge so rising-edge readers never race it
    always @(negedge clk_sys_i) lfsr_q <= lfsr_next(lfsr_q);
    always @(posedge clk_sys_i) rnd_bit <= lfsr_q[0];

    // bits of the first frame after release, one on every second edge as the block takes them
    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            edge_n <= 0;
            bit_sum <= 0;
        end else begin
            edge_n <= edge_n + 1;
            if (edge_n[0] && edge_n < (2 << (7 + ratio_sel))) begin
                bit_sum <= bit_sum + (mod_bit ? 1 : -1);
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // reset for five edges; idle outputs checked while held
    task automatic do_reset(input logic [2:0] sel, input logic [1:0] pat);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        ratio_sel <= sel;
        pattern <= pat;
        repeat (5) @(posedge clk_sys_i);
        check({fast_path, data_valid, khz_seen}, {1'b1, 1'b0, 14'h2000});
        nrst_i <= 1'b1;
    endtask

    // counts cycles up to the next word strobe; a stall counts as a mismatch
    task automatic wait_valid(input int max, output int n);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (data_valid !== 1'b1 && n < max);
        if (data_valid !== 1'b1) begin
            check(32'h0, 32'h1);
        end
    endtask

    initial begin
        logic [1:0] m;
        logic c;
        nrst_i = 1'b0;
        ratio_sel = 3'h4;
        mode_sel = 2'h0;
        crystal_sel = 1'b0;
        pattern = 2'h1;
        bad_count = 0;
        total_checks = 0;
        do_reset(3'h4, 2'h1);
        // modulator clock alternates from the first edge after release
        for (int k = 0; k < 20; k++) begin
            @(negedge clk_sys_i);
            check(mod_clk, k[0]);
        end
        // every mode code first, reserved one included, then random
        for (int i = 0; i < 16; i++) begin
            m = (i < 4) ? i[1:0] : lfsr_q[3:2];
            c = (i < 4) ? i[0] : lfsr_q[7];
            @(posedge clk_sys_i);
            mode_sel <= m;
            crystal_sel <= c;
            @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            check(mode_seen, exp_mode(m));
            check(khz_seen, exp_khz(m));
            check(osc_en, c);
        end
        // ratio 2048, steady +1: two fast words, then cascade at full scale
        wait_valid(9000, lat);
        check({fast_path, data}, {1'b1, 24'h400000});
        wait_valid(9000, lat);
        check(lat, 32'd4096);
        check({fast_path, data}, {1'b1, 24'h400000});
        wait_valid(9000, lat);
        check(fast_path, 1'b0);
        repeat (3) wait_valid(9000, lat);
        check({fast_path, data}, {1'b0, 24'h400000});
        // ratio 128, steady -1: negative full scale on both paths
        do_reset(3'h0, 2'h0);
        wait_valid(2000, base_lat);
        check({fast_path, data}, {1'b1, 24'hc00000});
        repeat (5) wait_valid(2000, lat);
        check(lat, 32'd256);
        check({fast_path, data}, {1'b0, 24'hc00000});
        // remaining codes with random bits: first word shifts by 2N - 256
        for (int s = 1; s < 8; s++) begin
            do_reset(s[2:0], 2'h2);
            wait_valid(40000, lat);
            check(lat - base_lat, (32'd2 << (7 + s)) - 32'd256);
            check(fast_path, 1'b1);
            check(data, exp_fast(bit_sum, s));
        end
        final_report();
    end

    // the planned run is about 91k cycles; give it some slack
    initial begin
        repeat (110000) @(posedge clk_sys_i);
        check(32'h0, 32'h1);
        final_report();
    end
endmodule // tb_decimation_clock_osr_control
